// File: core/tdct_defines.svh
/*
  Register indices, field positions, reset values and timing counts for the
  triple down-counting timer block.
  Assumes the including file has no conflicting macro names.
*/
`ifndef TDCT_DEFINES_SVH
`define TDCT_DEFINES_SVH

// Configuration register indices, one per timer
`define TDCT_CFG0_IDX 8'hb0
`define TDCT_CFG1_IDX 8'hb3
`define TDCT_CFG2_IDX 8'hb6
// Count high byte indices, one per timer
`define TDCT_HI0_IDX 8'hb1
`define TDCT_HI1_IDX 8'hb4
`define TDCT_HI2_IDX 8'hb7
// Count low byte indices, one per timer
`define TDCT_LO0_IDX 8'hb2
`define TDCT_LO1_IDX 8'hb5
`define TDCT_LO2_IDX 8'hb8
// Sticky completion flags, write one to clear
`define TDCT_STAT_IDX 8'hba
// Live count readback: low byte at base + 2*timer, high byte one above
`define TDCT_LIVE_BASE_IDX 8'hbc

// Configuration fields
`define TDCT_RUN_BIT 0
`define TDCT_SINGLE_BIT 1
`define TDCT_TIMER_CLOCK_SELECT_BIT 2
`define TDCT_CFG_W 3
`define TDCT_CFG_RESET 3'h0
`define TDCT_BYTE_RESET 8'h00

// Timing
`define TDCT_CLK_HZ 100000000
`define TDCT_SLOW_HZ 32000
`define TDCT_SLOW_DIV (`TDCT_CLK_HZ / `TDCT_SLOW_HZ)

`endif

// File: core/tdct_pkg.sv
/*
  Types shared by the timer block: counter state, register kinds, count word.
  Assumes the defines header is available for constants.
*/
package tdct_pkg;
  // Per-timer counter state
  typedef enum logic [0:0] {TDCT_HELD, TDCT_COUNT} tdct_state_t;
  // Kind of register selected by a bus address
  typedef enum logic [2:0] {
    TDCT_R_NONE, TDCT_R_CFG, TDCT_R_HI, TDCT_R_LO, TDCT_R_STAT, TDCT_R_LIVE
  } tdct_reg_kind_t;
  // Count value word
  typedef logic [15:0] tdct_count_t;
endpackage : tdct_pkg

// File: core/tdct_timer.sv
/*
  One 16-bit down counter with hold, start load, reload and single pass.
  Assumes the parent supplies the tick enable, the run and mode bits and
  clears the run bit when o_clear_run pulses.
*/
`timescale 1ns/1ps
`include "tdct_defines.svh"

module tdct_timer (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_run,
  input wire logic i_single,
  input wire logic i_tick,
  input wire tdct_pkg::tdct_count_t i_reload,
  output tdct_pkg::tdct_count_t o_count,
  output logic o_done,
  output logic o_clear_run
);
  import tdct_pkg::*;

  tdct_state_t state; // Held or counting
  tdct_state_t next_state;
  tdct_count_t count; // Live count
  tdct_count_t next_count;

  // Next state and count
  always_comb
  begin
    next_state = state;
    next_count = count;
    o_done = 1'b0;
    o_clear_run = 1'b0;
    case (state)
      TDCT_HELD:
      begin
        next_count = '0;
        if (i_run)
        begin
          // Data writes reach the count only here or at reload
          next_count = i_reload;
          next_state = TDCT_COUNT;
        end
      end
      TDCT_COUNT:
      begin
        if (!i_run)
        begin
          next_state = TDCT_HELD;
          next_count = '0;
        end
        else if (i_tick)
        begin
          if (count == '0)
          begin
            o_done = 1'b1;
            if (i_single)
            begin
              // Back to held; parent drops run on the same edge
              o_clear_run = 1'b1;
              next_state = TDCT_HELD;
              next_count = '0;
            end
            else
            begin
              next_count = i_reload;
            end
          end
          else
          begin
            next_count = count - 16'h0001;
          end
        end
      end
      default:
      begin
        next_state = TDCT_HELD;
      end
    endcase
  end

  // State registers
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state <= TDCT_HELD;
      count <= '0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
    end
  end

  assign o_count = count;

  sequence s_terminal;
    state == TDCT_COUNT && i_run && i_tick && count == '0;
  endsequence

  held_zero_a : assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !i_run |=> count == '0)
    else $error("count not cleared while run is low");
  start_load_a : assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (state == TDCT_HELD && i_run) |=> (state == TDCT_COUNT && count == $past(i_reload)))
    else $error("start did not load the data registers");
  reload_cont_a : assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (s_terminal and !i_single) |=> (state == TDCT_COUNT && count == $past(i_reload)))
    else $error("continuous mode did not reload");
  single_stop_a : assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (s_terminal and i_single) |-> o_clear_run ##1 (state == TDCT_HELD && count == '0))
    else $error("single pass did not stop");
  count_down_a : assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (state == TDCT_COUNT && i_run && i_tick && count != '0) |=> count == $past(count) - 16'h0001)
    else $error("count did not step down by one");
  done_cause_a : assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_done |-> (count == '0 && i_tick && state == TDCT_COUNT))
    else $error("completion without terminal count");

endmodule : tdct_timer

// File: core/tdct_top.sv
/*
  Three 16-bit down-counting timers behind an Avalon-MM slave with
  waitrequest. Each timer has a configuration byte and two count bytes.
  Assumes a 100 MHz clock; the slow timer clock is a 32 kHz enable derived
  here. Address is a word index; registers sit in data bits 7:0.
*/
`timescale 1ns/1ps
`include "tdct_defines.svh"

// Summary of operation
// - Three independent timers, each with own registers
// - Config bit 2 picks CPU or 32 kHz clock
// - Run bit low holds timer; high counts down
// - Continuous mode reloads at terminal count, continues
// - Single pass mode runs one period then stops
// - Single pass completion clears the run bit
// - Sixteen bit count: high and low byte registers
// - Count bytes read and write; both reset zero
// - Three config bits read, write, reset zero

module tdct_top (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [2:0] o_timer_done
);
  import tdct_pkg::*;

  localparam int NT = 3; // Timer count
  localparam logic [7:0] CFG_IDX [NT] = '{`TDCT_CFG0_IDX, `TDCT_CFG1_IDX, `TDCT_CFG2_IDX};
  localparam logic [7:0] HI_IDX [NT] = '{`TDCT_HI0_IDX, `TDCT_HI1_IDX, `TDCT_HI2_IDX};
  localparam logic [7:0] LO_IDX [NT] = '{`TDCT_LO0_IDX, `TDCT_LO1_IDX, `TDCT_LO2_IDX};
  localparam logic [11:0] SLOW_LAST = 12'(`TDCT_SLOW_DIV - 1); // Divider wrap

  logic [`TDCT_CFG_W-1:0] cfg [NT]; // Config bits per timer
  logic [`TDCT_CFG_W-1:0] next_cfg [NT];
  logic [7:0] cnt_hi [NT]; // Count high bytes
  logic [7:0] next_cnt_hi [NT];
  logic [7:0] cnt_lo [NT]; // Count low bytes
  logic [7:0] next_cnt_lo [NT];
  logic [NT-1:0] done_flag; // Sticky completion flags
  logic [NT-1:0] next_done_flag;
  logic rd_pend; // Read in its answer cycle
  logic next_rd_pend;
  logic [31:0] rd_data; // Registered read answer
  logic [31:0] next_rd_data;
  logic [11:0] slow_cnt; // 32 kHz divider
  logic [11:0] next_slow_cnt;
  logic slow_tick; // One-cycle slow enable
  logic wr_stb; // Accepted low-lane write
  tdct_reg_kind_t acc_kind; // Decoded register kind
  logic [1:0] acc_unit; // Decoded timer number
  tdct_count_t live [NT]; // Live counts
  logic [NT-1:0] t_done; // Terminal-count pulses
  logic [NT-1:0] t_clear; // Single-pass run clears
  logic [NT-1:0] t_tick; // Per-timer tick enables

  // Address to register kind
  function automatic tdct_reg_kind_t reg_kind(input logic [7:0] a);
    tdct_reg_kind_t k;
    k = TDCT_R_NONE;
    for (int i = 0; i < NT; i++)
    begin
      if (a == CFG_IDX[i])
        k = TDCT_R_CFG;
      else if (a == HI_IDX[i])
        k = TDCT_R_HI;
      else if (a == LO_IDX[i])
        k = TDCT_R_LO;
    end
    if (a == `TDCT_STAT_IDX)
      k = TDCT_R_STAT;
    else if (a >= `TDCT_LIVE_BASE_IDX && a < `TDCT_LIVE_BASE_IDX + 8'(2 * NT))
      k = TDCT_R_LIVE;
    return k;
  endfunction : reg_kind

  // Address to timer number
  function automatic logic [1:0] reg_unit(input logic [7:0] a);
    logic [1:0] u;
    logic [7:0] off;
    u = 2'd0;
    off = a - `TDCT_LIVE_BASE_IDX;
    for (int i = 0; i < NT; i++)
    begin
      if (a == CFG_IDX[i] || a == HI_IDX[i] || a == LO_IDX[i])
        u = 2'(i);
    end
    if (a >= `TDCT_LIVE_BASE_IDX)
      u = off[2:1];
    return u;
  endfunction : reg_unit

  assign acc_kind = reg_kind(i_avs_address);
  assign acc_unit = reg_unit(i_avs_address);
  // Writes never wait; only the low byte lane carries register data
  assign wr_stb = i_avs_write && i_avs_byteenable[0];
  // Reads wait exactly one cycle while the answer is registered
  assign o_avs_waitrequest = i_avs_read && !rd_pend;
  assign o_avs_readdata = rd_data;
  assign o_timer_done = done_flag;

  // Slow clock enable: one pulse every divider period
  always_comb
  begin
    next_slow_cnt = (slow_cnt == SLOW_LAST) ? 12'h000 : slow_cnt + 12'h001;
    slow_tick = (slow_cnt == SLOW_LAST);
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      slow_cnt <= 12'h000;
    else
      slow_cnt <= next_slow_cnt;
  end

  // Timer instances, one per register set
  for (genvar g = 0; g < NT; g++)
  begin : g_timer
    // CPU clock ticks every cycle; otherwise the slow enable
    assign t_tick[g] = cfg[g][`TDCT_TIMER_CLOCK_SELECT_BIT] ? 1'b1 : slow_tick;
    tdct_timer u_timer (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_run(cfg[g][`TDCT_RUN_BIT]),
      .i_single(cfg[g][`TDCT_SINGLE_BIT]),
      .i_tick(t_tick[g]),
      .i_reload({cnt_hi[g], cnt_lo[g]}),
      .o_count(live[g]),
      .o_done(t_done[g]),
      .o_clear_run(t_clear[g])
    );
  end

  // Register file next values
  always_comb
  begin
    for (int i = 0; i < NT; i++)
    begin
      next_cfg[i] = cfg[i];
      next_cnt_hi[i] = cnt_hi[i];
      next_cnt_lo[i] = cnt_lo[i];
      // Hardware clear first so a same-cycle software write wins
      if (t_clear[i])
        next_cfg[i][`TDCT_RUN_BIT] = 1'b0;
      if (wr_stb && acc_unit == 2'(i))
      begin
        // Reserved bits 7:3 are not stored and read as zero
        if (acc_kind == TDCT_R_CFG)
          next_cfg[i] = i_avs_writedata[`TDCT_CFG_W-1:0];
        else if (acc_kind == TDCT_R_HI)
          next_cnt_hi[i] = i_avs_writedata[7:0];
        else if (acc_kind == TDCT_R_LO)
          next_cnt_lo[i] = i_avs_writedata[7:0];
      end
    end
    // Completion flags: write one clears, a new event wins
    next_done_flag = done_flag;
    if (wr_stb && acc_kind == TDCT_R_STAT)
      next_done_flag = done_flag & ~i_avs_writedata[NT-1:0];
    next_done_flag = next_done_flag | t_done;
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      for (int i = 0; i < NT; i++)
      begin
        cfg[i] <= `TDCT_CFG_RESET;
        cnt_hi[i] <= `TDCT_BYTE_RESET;
        cnt_lo[i] <= `TDCT_BYTE_RESET;
      end
      done_flag <= '0;
    end
    else
    begin
      for (int i = 0; i < NT; i++)
      begin
        cfg[i] <= next_cfg[i];
        cnt_hi[i] <= next_cnt_hi[i];
        cnt_lo[i] <= next_cnt_lo[i];
      end
      done_flag <= next_done_flag;
    end
  end

  // Read path: capture in the wait cycle, present in the next
  always_comb
  begin
    next_rd_pend = i_avs_read && !rd_pend;
    next_rd_data = rd_data;
    if (i_avs_read && !rd_pend)
    begin
      // Unmapped indices answer zero
      next_rd_data = 32'h0000_0000;
      if (acc_kind == TDCT_R_CFG)
        next_rd_data[`TDCT_CFG_W-1:0] = cfg[acc_unit];
      else if (acc_kind == TDCT_R_HI)
        next_rd_data[7:0] = cnt_hi[acc_unit];
      else if (acc_kind == TDCT_R_LO)
        next_rd_data[7:0] = cnt_lo[acc_unit];
      else if (acc_kind == TDCT_R_STAT)
        next_rd_data[NT-1:0] = done_flag;
      else if (acc_kind == TDCT_R_LIVE)
        next_rd_data[7:0] = i_avs_address[0] ? live[acc_unit][15:8]
                                             : live[acc_unit][7:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rd_pend <= 1'b0;
      rd_data <= 32'h0000_0000;
    end
    else
    begin
      rd_pend <= next_rd_pend;
      rd_data <= next_rd_data;
    end
  end

  // Helper: cycles since the last slow tick
  logic [11:0] gap_cnt;
  always_ff @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      gap_cnt <= 12'h000;
    else
      gap_cnt <= slow_tick ? 12'h000 : gap_cnt + 12'h001;
  end

  sequence s_read_req;
    i_avs_read && !rd_pend;
  endsequence

  sequence s_read_ans;
    i_avs_read && !o_avs_waitrequest;
  endsequence

  slow_period_a : assert property (@(posedge i_clk) disable iff (!i_arst_n)
    slow_tick |-> gap_cnt == SLOW_LAST)
    else $error("slow enable period wrong");
  cpu_tick_a : assert property (@(posedge i_clk) disable iff (!i_arst_n)
    cfg[0][`TDCT_TIMER_CLOCK_SELECT_BIT] |-> t_tick[0])
    else $error("cpu clock select did not tick every cycle");
  run_clear_a : assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (t_clear[1] && !(wr_stb && acc_kind == TDCT_R_CFG)) |=> !cfg[1][`TDCT_RUN_BIT])
    else $error("single pass did not clear run");
  cfg_write_a : assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (wr_stb && acc_kind == TDCT_R_CFG && acc_unit == 2'd2)
      |=> cfg[2] == $past(i_avs_writedata[`TDCT_CFG_W-1:0]))
    else $error("config write not stored");
  data_write_a : assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (wr_stb && acc_kind == TDCT_R_LO && acc_unit == 2'd0)
      |=> cnt_lo[0] == $past(i_avs_writedata[7:0]))
    else $error("count low write not stored");
  read_ans_a : assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (s_read_req ##1 i_avs_read) |-> s_read_ans)
    else $error("read not answered after one wait cycle");
  read_cfg_a : assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (s_read_req and acc_kind == TDCT_R_CFG) |=> rd_data[31:`TDCT_CFG_W] == '0)
    else $error("reserved config bits not zero");
  done_sticky_a : assert property (@(posedge i_clk) disable iff (!i_arst_n)
    t_done[0] |=> done_flag[0])
    else $error("completion event lost");
  hold_run_a : assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !cfg[2][`TDCT_RUN_BIT] |=> live[2] == '0)
    else $error("timer not held while run low");

endmodule : tdct_top

// File: dv/tdct_top_bench.sv
/*
  Self-checking bench for the triple down-counting timer block.
  Assumes the core files and the defines header are on the include path.
*/
`timescale 1ns/1ps
`include "tdct_defines.svh"

module tdct_top_bench;
  import tdct_pkg::*;
  logic clk; // 100 MHz clock
  logic arst_n; // Active-low reset
  logic [7:0] bus_addr; // Word index
  logic bus_rd; // Read request
  logic bus_wr; // Write request
  logic [31:0] bus_wdata; // Write data
  logic [3:0] bus_be; // Byte enables
  logic [31:0] rdata; // Read data
  logic wait_req; // Slave stall
  logic [2:0] done; // Sticky completion flags
  int n_mismatch; // Failed comparisons
  int cmp_count; // All comparisons
  logic [31:0] rd_val; // Last value read

  tdct_top dut_u (
    .i_clk(clk),
    .i_arst_n(arst_n),
    .i_avs_address(bus_addr),
    .i_avs_read(bus_rd),
    .i_avs_write(bus_wr),
    .i_avs_writedata(bus_wdata),
    .i_avs_byteenable(bus_be),
    .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req),
    .o_timer_done(done)
  );

  // Free-running clock
  always #5 clk = ~clk;

  // One comparison, counted
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Write; held until waitrequest is seen low at an edge
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
    bus_addr <= a;
    bus_wdata <= {24'h0, d};
    bus_be <= be;
    bus_wr <= 1'b1;
    do @(posedge clk); while (wait_req !== 1'b0);
    bus_wr <= 1'b0;
    // One idle edge, so the next request starts in a fresh time step
    @(posedge clk);
  endtask : bus_write

  // Read; data taken at the same edge that ends the wait
  task automatic bus_read(input logic [7:0] a, output logic [31:0] v);
    int w; // Edges until the answer
    w = 0;
    bus_addr <= a;
    bus_rd <= 1'b1;
    do
    begin
      @(posedge clk);
      w++;
    end
    while (wait_req !== 1'b0);
    v = rdata;
    bus_rd <= 1'b0;
    // One wait state, answer at the second edge
    check("read edges", 32'(w), 32'h2);
    @(posedge clk);
  endtask : bus_read

  // Edges until a flag is seen; read at the edge, so one edge late
  task automatic wait_done(input int t, output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (done[t] !== 1'b1 && n < 20000);
  endtask : wait_done

  // Reset values, read-back, dropped writes
  task automatic reg_test();
    logic [7:0] base;
    check("flags at reset", {29'h0, done}, 32'h0);
    for (int t = 0; t < 3; t++)
    begin
      base = `TDCT_CFG0_IDX + 8'(3 * t);
      for (int k = 0; k < 3; k++)
      begin
        bus_read(base + 8'(k), rd_val);
        check("reset value", rd_val, 32'h0);
      end
      // Reserved bits set on purpose; run stays off
      bus_write(base, 8'hfe, 4'h1);
      bus_read(base, rd_val);
      check("config bits", rd_val, 32'h6);
      bus_write(base, 8'h00, 4'h1);
      bus_read(base, rd_val);
      check("config clear", rd_val, 32'h0);
      bus_write(base + 8'h1, 8'ha5 + 8'(t), 4'h1);
      bus_write(base + 8'h2, 8'h5a + 8'(t), 4'h1);
      // Lane 0 disabled: must not land
      bus_write(base + 8'h2, 8'hff, 4'h0);
      bus_read(base + 8'h1, rd_val);
      check("high byte", rd_val, 32'(8'ha5 + 8'(t)));
      bus_read(base + 8'h2, rd_val);
      check("low byte", rd_val, 32'(8'h5a + 8'(t)));
    end
    bus_write(8'hc5, 8'h33, 4'h1);
    bus_read(8'hc5, rd_val);
    check("unmapped", rd_val, 32'h0);
    $display("Test registers done");
  endtask : reg_test

  // One pass on each timer in turn
  task automatic single_test();
    int n;
    logic [7:0] base;
    for (int t = 0; t < 3; t++)
    begin
      base = `TDCT_CFG0_IDX + 8'(3 * t);
      bus_write(`TDCT_STAT_IDX, 8'h07, 4'h1);
      bus_write(base + 8'h1, 8'h00, 4'h1);
      bus_write(base + 8'h2, 8'(3 + t), 4'h1);
      // Run, single pass, CPU clock; reserved bits zero
      bus_write(base, 8'h07, 4'h1);
      wait_done(t, n);
      // N + 1 ticks, plus one edge for the flag to show
      check("single period", 32'(n), 32'(3 + t + 2));
      check("other flags", {29'h0, done & ~(3'h1 << t)}, 32'h0);
      bus_read(base, rd_val);
      check("run cleared", rd_val, 32'h6);
      bus_read(`TDCT_LIVE_BASE_IDX + 8'(2 * t), rd_val);
      check("count at stop", rd_val, 32'h0);
      bus_read(`TDCT_LIVE_BASE_IDX + 8'(2 * t + 1), rd_val);
      check("high at stop", rd_val, 32'h0);
      bus_read(`TDCT_STAT_IDX, rd_val);
      check("status flag", rd_val, 32'(3'h1 << t));
      bus_write(`TDCT_STAT_IDX, 8'(1 << t), 4'h1);
      repeat (40) @(posedge clk);
      check("no second pass", {29'h0, done}, 32'h0);
      bus_write(base, 8'h00, 4'h1);
    end
    $display("Test single pass done");
  endtask : single_test

  // Continuous reload on timer 0; new low byte waits for reload
  task automatic cont_test();
    int n;
    bus_write(`TDCT_STAT_IDX, 8'h07, 4'h1);
    bus_write(`TDCT_HI0_IDX, 8'h01, 4'h1);
    bus_write(`TDCT_LO0_IDX, 8'h00, 4'h1);
    bus_write(`TDCT_CFG0_IDX, 8'h05, 4'h1);
    wait_done(0, n);
    // 0x100 + 1 ticks, plus one edge for the flag to show
    check("first period", 32'(n), 32'h102);
    bus_write(`TDCT_STAT_IDX, 8'h01, 4'h1);
    // Mid-run write: the period in progress keeps 0x100
    bus_write(`TDCT_LO0_IDX, 8'h10, 4'h1);
    wait_done(0, n);
    // Four edges went to the two writes
    check("reload period", 32'(n + 4), 32'h101);
    bus_write(`TDCT_STAT_IDX, 8'h01, 4'h1);
    wait_done(0, n);
    check("new period", 32'(n + 2), 32'h111);
    bus_read(`TDCT_CFG0_IDX, rd_val);
    check("run kept", rd_val, 32'h5);
    bus_write(`TDCT_CFG0_IDX, 8'h00, 4'h1);
    bus_write(`TDCT_STAT_IDX, 8'h01, 4'h1);
    repeat (600) @(posedge clk);
    check("held timer", {29'h0, done}, 32'h0);
    $display("Test continuous done");
  endtask : cont_test

  // Slow clock on timer 2: two ticks of 3125 clocks
  task automatic slow_test();
    int n;
    bus_write(`TDCT_STAT_IDX, 8'h07, 4'h1);
    bus_write(`TDCT_HI2_IDX, 8'h00, 4'h1);
    bus_write(`TDCT_LO2_IDX, 8'h01, 4'h1);
    bus_write(`TDCT_CFG2_IDX, 8'h01, 4'h1);
    wait_done(2, n);
    // Tick phase is free-running, so only a window is known
    check("slow lower", 32'(n > 3126), 32'h1);
    check("slow upper", 32'(n <= 6251), 32'h1);
    bus_write(`TDCT_CFG2_IDX, 8'h00, 4'h1);
    $display("Test slow clock done");
  endtask : slow_test

  // Counts, verdict, end of run
  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    bus_addr = 8'h00;
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    bus_wdata = 32'h0;
    bus_be = 4'h0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    reg_test();
    single_test();
    cont_test();
    slow_test();
    wrap_up();
  end

  // Watchdog: whole run needs under 9000 cycles
  initial
  begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    $display("Watchdog expired");
    wrap_up();
  end
endmodule : tdct_top_bench
